// File: hdl/mcl_cfg.svh
// Constants for the move, compare and logic datapath.
// What this block does
// RL1: Decode opcode, source field, destination field.
// RL2: Moves copy source to result, then destination.
// RL3: N from sign bit, Z when result zero.
// RL4: Move, test, clear always clear V.
// RL5: Word compare: 17-bit source minus destination, no write.
// RL6: Compares change only condition codes.
// RL7: Compare V: signs differ, result sign differs.
// RL8: Word compare carry is difference bit 16.
// RL9: Byte compare: 9-bit difference, bits 7, 8.
// RL10: Word bit test ANDs, updates flags only.
// RL11: Byte bit test likewise on bytes.
// RL12: Word bit clear writes dst AND NOT src.
// RL13: Byte bit clear writes destination byte only.
// RL14: Move, test, clear keep carry unchanged.
// RL15: Byte forms use and alter low byte only.
`ifndef MCL_CFG_SVH
`define MCL_CFG_SVH
`define MCL_OP_HI      15
`define MCL_OP_LO      12
`define MCL_SRC_HI     11
`define MCL_SRC_LO     6
`define MCL_DST_HI     5
`define MCL_DST_LO     0
`define MCL_MODE_HI    5
`define MCL_MODE_LO    3
`define MCL_REG_HI     2
`define MCL_REG_LO     0
`define MCL_BYTE_BIT   3
`define MCL_W_SIGN     15
`define MCL_B_SIGN     7
`define MCL_W_CARRY    16
`define MCL_B_CARRY    8
`define MCL_OPC_MOVE   3'h1
`define MCL_OPC_CMP    3'h2
`define MCL_OPC_TEST   3'h3
`define MCL_OPC_CLEAR  3'h4
`define MCL_OPC_HI     2
`define MCL_OPC_LO     0
`define MCL_LO_BIT     0
`define MCL_B_HI       7
`define MCL_W_HI       15
`define MCL_WORD_BITS  16
`define MCL_BYTE_ZERO  8'h00
`define MCL_WORD_ZERO  16'h0000
`define MCL_CLR_BIT    1'b0
`define MCL_BORROW_PAD 1'b0
`endif

// File: hdl/mcl_pkg.sv
// Types shared by the move, compare and logic datapath.
`default_nettype none
package mcl_pkg;
  typedef enum logic [2:0] {
    MCL_NONE,
    MCL_COPY_WORD, MCL_COPY_BYTE,
    MCL_COMPARE_WORD, MCL_COMPARE_BYTE,
    MCL_AND_TEST_WORD, MCL_AND_TEST_BYTE,
    MCL_AND_NOT_CLEAR_WORD
  } mcl_kind_t;
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] regsel;
  } mcl_addr_t;
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } mcl_cc_t;
endpackage
`default_nettype wire

// File: hdl/mcl_datapath.sv
// Execution datapath for move, compare, bit test and bit clear.
`timescale 1ns/100ps
`default_nettype none
`include "mcl_cfg.svh"
module mcl_datapath (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_start,
  input  wire logic [15:0]       i_instr,
  input  wire logic [15:0]       i_src,
  input  wire logic [15:0]       i_dst,
  input  wire mcl_pkg::mcl_cc_t  i_cc,
  output logic                   o_hit,
  output mcl_pkg::mcl_addr_t     o_src_addr,
  output mcl_pkg::mcl_addr_t     o_dst_addr,
  output logic                   o_done,
  output logic [15:0]            o_result,
  output logic                   o_wr_en,
  output logic                   o_wr_byte,
  output mcl_pkg::mcl_cc_t       o_cc
);
  import mcl_pkg::*;

  // ==========================================================
  // Instruction decode
  // ==========================================================
  wire logic [3:0] op_field;
  wire logic [2:0] op_low;
  wire logic       is_byte;
  wire logic       is_move;
  wire logic       is_cmp;
  wire logic       is_test;
  wire logic       is_clear;
  wire logic [3:0] kind_hot;
  wire logic       hit;
  wire logic       take;
  wire logic [5:0] src_f;
  wire logic [5:0] dst_f;

  assign op_field = i_instr[`MCL_OP_HI:`MCL_OP_LO];   // RL1
  assign op_low   = op_field[`MCL_OPC_HI:`MCL_OPC_LO];
  assign is_byte  = op_field[`MCL_BYTE_BIT];          // RL15
  assign is_move  = (op_low == `MCL_OPC_MOVE);        // RL2
  assign is_cmp   = (op_low == `MCL_OPC_CMP);         // RL5 RL9
  assign is_test  = (op_low == `MCL_OPC_TEST);        // RL10 RL11
  assign is_clear = (op_low == `MCL_OPC_CLEAR);       // RL12 RL13
  // Every other operation code, the add and subtract families among
  // them, belongs to other execution paths and is left alone here.
  assign kind_hot = {is_clear, is_test, is_cmp, is_move};
  assign hit      = |kind_hot;
  assign take     = i_start & hit;
  assign src_f    = i_instr[`MCL_SRC_HI:`MCL_SRC_LO]; // RL1
  assign dst_f    = i_instr[`MCL_DST_HI:`MCL_DST_LO]; // RL1

  // ==========================================================
  // Address fields
  // ==========================================================
  // The fetch logic resolves the addressing modes; this block only
  // splits the fields so both sides agree on one decode.
  wire logic [2:0] src_mode;
  wire logic [2:0] src_reg;
  wire logic [2:0] dst_mode;
  wire logic [2:0] dst_reg;

  assign src_mode   = src_f[`MCL_MODE_HI:`MCL_MODE_LO];
  assign src_reg    = src_f[`MCL_REG_HI:`MCL_REG_LO];
  assign dst_mode   = dst_f[`MCL_MODE_HI:`MCL_MODE_LO];
  assign dst_reg    = dst_f[`MCL_REG_HI:`MCL_REG_LO];
  assign o_hit      = hit;
  assign o_src_addr = '{mode: src_mode, regsel: src_reg};
  assign o_dst_addr = '{mode: dst_mode, regsel: dst_reg};

  // ==========================================================
  // Operand selection
  // ==========================================================
  // Byte forms look only at the low byte of each operand; the upper
  // byte is forced to zero so the word paths cannot see it.
  wire logic [7:0]  src_lo;
  wire logic [7:0]  dst_lo;
  wire logic [15:0] src_eff;
  wire logic [15:0] dst_eff;

  assign src_lo  = i_src[`MCL_B_HI:`MCL_LO_BIT];
  assign dst_lo  = i_dst[`MCL_B_HI:`MCL_LO_BIT];
  assign src_eff = is_byte ? {`MCL_BYTE_ZERO, src_lo} : i_src; // RL15
  assign dst_eff = is_byte ? {`MCL_BYTE_ZERO, dst_lo} : i_dst; // RL15

  // ==========================================================
  // Subtractors for compare
  // ==========================================================
  // Both widths are always built; the top bit of each holds the borrow.
  wire logic [16:0] diff_w;
  wire logic [8:0]  diff_b;
  wire logic [15:0] cmp_r;

  assign diff_w = {`MCL_BORROW_PAD, i_src} - {`MCL_BORROW_PAD, i_dst};   // RL5
  assign diff_b = {`MCL_BORROW_PAD, src_lo} - {`MCL_BORROW_PAD, dst_lo}; // RL9
  assign cmp_r  = is_byte ? {`MCL_BYTE_ZERO, diff_b[`MCL_B_HI:`MCL_LO_BIT]}
                          : diff_w[`MCL_W_HI:`MCL_LO_BIT];

  // ==========================================================
  // Bitwise test and clear
  // ==========================================================
  wire logic [15:0] and_r;
  wire logic [15:0] clear_r;

  for (genvar b = 0; b < `MCL_WORD_BITS; b++) begin : g_bit
    assign and_r[b]   = dst_eff[b] & src_eff[b];  // RL10 RL11
    assign clear_r[b] = dst_eff[b] & ~src_eff[b]; // RL12 RL13
  end

  // ==========================================================
  // Result selection
  // ==========================================================
  logic [15:0] r_val;

  always_comb begin
    case (op_low)
      `MCL_OPC_MOVE: begin
        r_val = src_eff; // RL2
      end
      `MCL_OPC_CMP: begin
        r_val = cmp_r;   // RL5 RL9
      end
      `MCL_OPC_TEST: begin
        r_val = and_r;   // RL10 RL11
      end
      default: begin
        r_val = clear_r; // RL12 RL13
      end
    endcase
  end

  // ==========================================================
  // Negative and zero
  // ==========================================================
  wire logic n_word;
  wire logic n_byte;
  wire logic z_word;
  wire logic z_byte;
  wire logic n_new;
  wire logic z_new;

  assign n_word = r_val[`MCL_W_SIGN];                                 // RL3 RL6
  assign n_byte = r_val[`MCL_B_SIGN];                                 // RL3 RL6 RL11
  assign z_word = (r_val == `MCL_WORD_ZERO);                          // RL3 RL6
  assign z_byte = (r_val[`MCL_B_HI:`MCL_LO_BIT] == `MCL_BYTE_ZERO);   // RL3 RL6
  assign n_new  = is_byte ? n_byte : n_word;
  assign z_new  = is_byte ? z_byte : z_word;

  // ==========================================================
  // Overflow and carry
  // ==========================================================
  wire logic s_sign_w;
  wire logic s_sign_b;
  wire logic d_sign_w;
  wire logic d_sign_b;
  wire logic v_word;
  wire logic v_byte;
  wire logic c_word;
  wire logic c_byte;
  wire logic v_cmp;
  wire logic c_cmp;
  wire logic v_new;
  wire logic c_new;

  assign s_sign_w = i_src[`MCL_W_SIGN];
  assign s_sign_b = i_src[`MCL_B_SIGN];
  assign d_sign_w = i_dst[`MCL_W_SIGN];
  assign d_sign_b = i_dst[`MCL_B_SIGN];
  // Overflow when the operand signs differ and the difference has
  // moved away from the source sign.
  assign v_word   = (s_sign_w != d_sign_w) & (s_sign_w != n_word); // RL7
  assign v_byte   = (s_sign_b != d_sign_b) & (s_sign_b != n_byte); // RL7
  // The carry is the raw borrow bit: set on a borrow, clear on a carry out.
  assign c_word   = diff_w[`MCL_W_CARRY];                         // RL8
  assign c_byte   = diff_b[`MCL_B_CARRY];                         // RL9
  assign v_cmp    = is_byte ? v_byte : v_word;
  assign c_cmp    = is_byte ? c_byte : c_word;
  // Only compare produces V and C; the others clear V and keep C.
  assign v_new    = is_cmp ? v_cmp : `MCL_CLR_BIT;                // RL4
  assign c_new    = is_cmp ? c_cmp : i_cc.c;                      // RL14

  // ==========================================================
  // Write control
  // ==========================================================
  // Compare and bit test change only the flags, so they never write.
  wire logic wr_new;

  assign wr_new = is_move | is_clear; // RL2 RL5 RL6 RL10 RL12

  // ==========================================================
  // Next values
  // ==========================================================
  // Result, width and flags hold between accepted starts, so the
  // writeback side may take them at any time after done.
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic        done_reg;
  logic        done_next;
  logic        wr_reg;
  logic        wr_next;
  logic        wr_byte_reg;
  logic        wr_byte_next;
  mcl_cc_t     cc_reg;
  mcl_cc_t     cc_next;
  mcl_cc_t     cc_calc;

  assign cc_calc.n = n_new;
  assign cc_calc.z = z_new;
  assign cc_calc.v = v_new;
  assign cc_calc.c = c_new;
  assign done_next = take;
  assign wr_next   = take & wr_new; // RL2 RL12 RL13

  always_comb begin
    result_next  = result_reg;
    wr_byte_next = wr_byte_reg;
    cc_next      = cc_reg;
    if (take) begin
      result_next  = r_val;
      wr_byte_next = is_byte; // RL15
      cc_next      = cc_calc;
    end
  end

  // ==========================================================
  // Done register
  // ==========================================================
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      done_reg <= `MCL_CLR_BIT;
    end else begin
      done_reg <= done_next;
    end
  end

  // ==========================================================
  // Write strobe register
  // ==========================================================
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_reg <= `MCL_CLR_BIT;
    end else begin
      wr_reg <= wr_next;
    end
  end

  // ==========================================================
  // Byte write register
  // ==========================================================
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_byte_reg <= `MCL_CLR_BIT;
    end else begin
      wr_byte_reg <= wr_byte_next;
    end
  end

  // ==========================================================
  // Result register
  // ==========================================================
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      result_reg <= `MCL_WORD_ZERO;
    end else begin
      result_reg <= result_next;
    end
  end

  // ==========================================================
  // Condition code register
  // ==========================================================
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cc_reg <= '0;
    end else begin
      cc_reg <= cc_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign o_done    = done_reg;
  assign o_result  = result_reg;
  assign o_wr_en   = wr_reg;
  assign o_wr_byte = wr_byte_reg;
  assign o_cc      = cc_reg;
endmodule
`default_nettype wire

// File: dv/mcl_writeback_model.sv
// Writeback partner that holds the destination word.
`timescale 1ns/100ps
`default_nettype none
module mcl_writeback_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_wr_en,
  input  wire logic        i_wr_byte,
  input  wire logic [15:0] i_result,
  output logic      [15:0] o_word
);
  // A byte write keeps the upper half, so a stray word write shows up.
  always_ff @(posedge i_sys_clk)
    if (!i_rst_n) o_word <= 16'hFFFF;
    else if (i_wr_en) o_word <= i_wr_byte ? {o_word[15:8], i_result[7:0]} : i_result;
endmodule
`default_nettype wire

// File: dv/mcl_datapath_properties.sv
// Concurrent checks on the datapath ports.
`timescale 1ns/100ps
`default_nettype none
module mcl_datapath_properties (
  input wire logic             i_sys_clk,
  input wire logic             i_rst_n,
  input wire logic             i_start,
  input wire logic [15:0]      i_instr,
  input wire logic [15:0]      i_src,
  input wire mcl_pkg::mcl_cc_t i_cc,
  input wire logic             o_hit,
  input wire logic             o_done,
  input wire logic [15:0]      o_result,
  input wire logic             o_wr_en,
  input wire mcl_pkg::mcl_cc_t o_cc
);
  import mcl_pkg::*;
  wire go  = i_start && o_hit;
  wire cmp = go && i_instr[14:12] == 3'h2;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  chk_done_follows: assert property (go |=> o_done) else $error("done missing");
  chk_refused_quiet: assert property (!go |=> !o_done && !o_wr_en) else $error("done without start");
  chk_compare_nowrite: assert property (cmp |=> !o_wr_en) else $error("compare wrote");
  chk_test_nowrite: assert property (go && i_instr[14:12] == 3'h3 |=> !o_wr_en) else $error("test wrote");
  chk_move_copies: assert property (go && i_instr[15:12] == 4'h1 |=> o_result == $past(i_src) && o_cc.n == $past(i_src[15])) else $error("move value");
  chk_v_cleared: assert property (go && !cmp |=> !o_cc.v) else $error("overflow set");
  chk_carry_kept: assert property (go && !cmp |=> o_cc.c == $past(i_cc.c)) else $error("carry changed");
  chk_byte_upper: assert property (go && i_instr[15] |=> o_result[15:8] == 8'h00) else $error("byte upper");
endmodule
bind mcl_datapath mcl_datapath_properties i_mcl_datapath_properties (.*);
`default_nettype wire

// File: dv/move_compare_logic_ops_test.sv
// Self-checking bench for the move, compare and logic datapath.
`timescale 1ns/100ps
`default_nettype none
module move_compare_logic_ops_test;
  import mcl_pkg::*;
  logic        i_sys_clk = 0, i_rst_n = 0, i_start = 0, o_hit, o_done, o_wr_en, o_wr_byte;
  logic [15:0] i_instr = 0, i_src = 0, i_dst = 0, o_result, mem;
  mcl_cc_t     i_cc = '0, o_cc;
  mcl_addr_t   o_src_addr, o_dst_addr;
  int          mismatches = 0, n_compared = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  mcl_datapath i_mcl_datapath (.*);
  mcl_writeback_model i_mcl_writeback_model (.i_sys_clk, .i_rst_n, .i_wr_en(o_wr_en),
    .i_wr_byte(o_wr_byte), .i_result(o_result), .o_word(mem));
  task automatic chk(string name, logic [31:0] e, s);
    n_compared++;
    if (s !== e) mismatches++;
    if (s !== e) $display("unexpected %s for %h expected %h seen %h", name, i_instr, e, s);
  endtask
  task automatic s_decode;
    @(posedge i_sys_clk) i_instr <= 16'h1A5C;
    #1 chk("decode", 13'h1A5C, {o_hit, o_src_addr, o_dst_addr});
    @(posedge i_sys_clk) i_instr <= 16'h8000;
    #1 chk("decode", 13'h0000, {o_hit, o_src_addr, o_dst_addr});
  endtask
  // Seen word is done, write, byte write, result and flags.
  task automatic op(logic [15:0] i, s, d, logic [3:0] c, logic [31:0] e);
    @(posedge i_sys_clk);
    {i_instr, i_src, i_dst, i_cc, i_start} <= {i, s, d, c, 1'b1};
    @(posedge i_sys_clk);
    i_start <= 0;
    #1 chk("outputs", e, {o_done, o_wr_en, o_wr_byte, o_result, o_cc});
  endtask
  task automatic s_move;
    op(16'h1000, 16'h8000, 16'h0, 4'h1, {3'b110, 16'h8000, 4'h9});
    op(16'h9000, 16'h125A, 16'h0, 4'h1, {3'b111, 16'h005A, 4'h1});
    @(posedge i_sys_clk) #1 chk("destination", 16'h805A, mem);
  endtask
  task automatic s_cmp;
    op(16'h2000, 16'h0001, 16'h0002, 4'hF, {3'b100, 16'hFFFF, 4'h9});
    op(16'h2000, 16'h8000, 16'h0001, 4'hF, {3'b100, 16'h7FFF, 4'h2});
    op(16'hA000, 16'hFF80, 16'h0080, 4'hF, {3'b101, 16'h0000, 4'h4});
    op(16'hA000, 16'h0001, 16'h0002, 4'h0, {3'b101, 16'h00FF, 4'h9});
  endtask
  task automatic s_logic;
    op(16'h3000, 16'h00F0, 16'h0F00, 4'h1, {3'b100, 16'h0000, 4'h5});
    op(16'hB000, 16'hFF80, 16'h0080, 4'h0, {3'b101, 16'h0080, 4'h8});
    op(16'hC000, 16'hFF0F, mem, 4'h1, {3'b111, 16'h0050, 4'h1});
    @(posedge i_sys_clk) #1 chk("destination", 16'h8050, mem);
    op(16'h4000, 16'h00FF, 16'h8F0F, 4'h0, {3'b110, 16'h8F00, 4'h8});
    op(16'h5000, 16'h1234, 16'h4321, 4'h0, {3'b000, 16'h8F00, 4'h8});
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial #100000 begin
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1;
    s_decode;
    s_move;
    s_cmp;
    s_logic;
    report_and_stop;
  end
endmodule
`default_nettype wire
